/* File: verilog/refresh_timeout_pkg.sv */
// Constants, types and register layout of the refresh timeout arbiter
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package refresh_timeout_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int REF_TICK_NS = 30000;
  localparam int WATCHDOG_NS = 15000;
  localparam int STEAL_NS = 450;
  localparam int REF_TICK_CYCLES = REF_TICK_NS / CLK_PERIOD_NS;
  localparam int WATCHDOG_CYCLES = (WATCHDOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEAL_CYCLES = STEAL_NS / CLK_PERIOD_NS;

  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  localparam int CTRL_STATIC_BIT = 0;
  localparam int CTRL_CLR_OVD_BIT = 1;
  localparam logic [23:0] TIMING_RESET = 24'h266432;
  localparam int T_SETUP_POS = 0;
  localparam int T_PRE_POS = 4;
  localparam int T_SEL_POS = 8;
  localparam int T_DONE_POS = 12;
  localparam int T_SYNC_POS = 16;
  localparam int T_WR_POS = 20;
  localparam int ST_ROW_POS = 0;
  localparam int ST_REQ_BIT = 8;
  localparam int ST_GRANT_BIT = 9;
  localparam int ST_OVD_BIT = 10;
  localparam int ST_STATE_POS = 16;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HOST = 5'h02,
    S_HOLD = 5'h04,
    S_REFR = 5'h08,
    S_STEAL = 5'h10
  } ctl_state_t;

  typedef struct packed {
    logic precharge;
    logic chip_select_strobe;
    logic mem_sync;
    logic write_strobe;
  } mem_ctl_t;

endpackage : refresh_timeout_pkg

/* File: verilog/refresh_timeout_arbiter.sv */
// Refresh scheduling, watchdog cycle steal and access timing chain
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module refresh_timeout_arbiter
  import refresh_timeout_pkg::*;
#(
  parameter int ROW_W = 5
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic host_access_request_i,
  input wire logic host_write_i,
  input wire logic host_proceed_i,
  input wire logic [ROW_W-1:0] host_row_i,
  input wire logic memory_supply_low_i,
  output mem_ctl_t mem_ctl_o,
  output logic [ROW_W-1:0] matrix_row_lines_o,
  output logic refresh_grant_o,
  output logic refresh_overdue_o,
  output logic host_done_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] req_s1;
    logic [3:0] req_s2;
    logic [ROW_W-1:0] row_s1;
    logic [ROW_W-1:0] row_s2;
    ctl_state_t st;
    logic [5:0] tcnt;
    logic [3:0] scnt;
    logic [9:0] tick_cnt;
    logic [8:0] wd_cnt;
    logic [ROW_W-1:0] row_cnt;
    logic ref_req;
    logic grant;
    logic overdue;
    logic ovd_seen;
    logic host_wr;
    logic done_latch;
    logic host_done;
    logic req_wait;
    mem_ctl_t ctl;
    logic [ROW_W-1:0] row_lines;
    logic static_mode;
    logic [23:0] timing;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic req_p;
  logic wr_p;
  logic proceed_p;
  logic supply_low_p;
  logic tick;
  logic [5:0] t_setup;
  logic [5:0] t_pre;
  logic [5:0] t_sel;
  logic [5:0] t_done;
  logic [5:0] t_sync;
  logic [5:0] t_wr_end;
  logic wb_req;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic ref_complete;
  logic chain_start;

  // Byte lane mask from the Wishbone select lines
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  assign req_p = s_q.req_s2[0];
  assign wr_p = s_q.req_s2[1];
  assign proceed_p = s_q.req_s2[2];
  assign supply_low_p = s_q.req_s2[3];

  // Taps are measured from the end of the address setup delay, except the write end tap, which is measured from the sync tap
  assign t_setup = {2'b00, s_q.timing[T_SETUP_POS +: 4]};
  assign t_pre = t_setup + {2'b00, s_q.timing[T_PRE_POS +: 4]};
  assign t_sel = t_setup + {2'b00, s_q.timing[T_SEL_POS +: 4]};
  assign t_done = t_setup + {2'b00, s_q.timing[T_DONE_POS +: 4]};
  assign t_sync = t_setup + {2'b00, s_q.timing[T_SYNC_POS +: 4]};
  assign t_wr_end = t_sync + {2'b00, s_q.timing[T_WR_POS +: 4]};

  assign wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_STATIC_BIT] = s_q.static_mode;
    status_word = 32'h0000_0000;
    status_word[ST_ROW_POS +: ROW_W] = s_q.row_cnt;
    status_word[ST_REQ_BIT] = s_q.ref_req;
    status_word[ST_GRANT_BIT] = s_q.grant;
    status_word[ST_OVD_BIT] = s_q.ovd_seen;
    status_word[ST_STATE_POS +: 5] = s_q.st;
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.req_s1 = {memory_supply_low_i, host_proceed_i, host_write_i,
                  host_access_request_i};
    s_d.req_s2 = s_q.req_s1;
    s_d.row_s1 = host_row_i;
    s_d.row_s2 = s_q.row_s1;
    s_d.host_done = 1'b0;
    s_d.overdue = 1'b0;
    ref_complete = 1'b0;
    chain_start = 1'b0;
    tick = 1'b0;

    // Refresh tick divider, stopped only by low memory supply
    if (supply_low_p) begin
      s_d.tick_cnt = '0;
    end else if (s_q.tick_cnt == 10'(REF_TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 10'd1;
    end

    if (tick) begin
      s_d.row_cnt = s_q.row_cnt + ROW_W'(1);
    end

    if (s_q.tcnt != 6'h3f) begin
      s_d.tcnt = s_q.tcnt + 6'd1;
    end

    // The synchronised request lags the host; it must drop before a new access
    if (!req_p) begin
      s_d.req_wait = 1'b0;
    end

    unique case (s_q.st)
      S_IDLE: begin
        s_d.ctl = '{precharge: 1'b1, default: 1'b0};
        s_d.done_latch = 1'b0;
        if (s_q.ref_req) begin
          // Refresh wins arbitration against a host request
          s_d.grant = 1'b1;
          s_d.st = S_REFR;
          chain_start = 1'b1;
          s_d.row_lines = s_q.row_cnt;
        end else if (req_p && !s_q.req_wait) begin
          s_d.st = S_HOST;
          s_d.host_wr = wr_p;
          chain_start = 1'b1;
          s_d.row_lines = s_q.row_s2;
        end
      end
      S_HOST, S_HOLD, S_REFR: begin
        if (s_q.tcnt == t_pre) begin
          s_d.ctl.precharge = 1'b0;
        end
        if (s_q.tcnt == t_sel) begin
          s_d.ctl.chip_select_strobe = 1'b1;
        end
        if (s_q.tcnt == t_sync) begin
          s_d.ctl.mem_sync = 1'b1;
          s_d.ctl.write_strobe = s_q.host_wr & (s_q.st != S_REFR);
        end
        if (s_q.tcnt == t_wr_end) begin
          s_d.ctl.write_strobe = 1'b0;
        end
        if (s_q.st == S_REFR) begin
          if (s_q.tcnt == t_done) begin
            ref_complete = 1'b1;
            s_d.grant = 1'b0;
            s_d.st = S_IDLE;
            s_d.ctl = '{precharge: 1'b1, default: 1'b0};
          end
        end else if (s_q.st == S_HOST) begin
          if (s_q.tcnt == t_done) begin
            s_d.done_latch = 1'b1;
            s_d.st = S_HOLD;
          end
        end else if (s_q.overdue) begin
          // Interrupt the hold and steal a refresh from the frozen access, then return to S_HOLD
          s_d.grant = 1'b1;
          s_d.st = S_STEAL;
          s_d.scnt = 4'(STEAL_CYCLES - 1);
          s_d.ctl = '{chip_select_strobe: 1'b1, default: 1'b0};
          s_d.row_lines = s_q.row_cnt;
        end else if (proceed_p && s_q.tcnt >= t_wr_end) begin
          // The host may not cut the write strobe short
          s_d.host_done = 1'b1;
          s_d.req_wait = 1'b1;
          s_d.done_latch = 1'b0;
          s_d.host_wr = 1'b0;
          s_d.st = S_IDLE;
          s_d.ctl = '{precharge: 1'b1, default: 1'b0};
        end
      end
      S_STEAL: begin
        // Host latches (done_latch, host_wr) stay frozen meanwhile
        if (s_q.scnt == 4'd0) begin
          ref_complete = 1'b1;
          s_d.grant = 1'b0;
          s_d.st = S_HOLD;
          s_d.row_lines = s_q.row_s2;
          s_d.ctl = '{chip_select_strobe: 1'b1, mem_sync: 1'b1, default: 1'b0};
        end else begin
          s_d.scnt = s_q.scnt - 4'd1;
        end
      end
    endcase

    if (chain_start) begin
      s_d.tcnt = '0;
    end

    // Request flip-flop; a new tick wins over completion clearing
    if (ref_complete) begin
      s_d.ref_req = 1'b0;
      s_d.wd_cnt = '0;
    end
    if (tick && !s_q.static_mode) begin
      s_d.ref_req = 1'b1;
    end

    // Watchdog runs while a request is pending outside S_STEAL; host hold locks grant out
    if (s_q.ref_req && !ref_complete && s_q.st != S_STEAL) begin
      if (s_q.wd_cnt == 9'(WATCHDOG_CYCLES - 1)) begin
        s_d.overdue = s_q.done_latch;
        s_d.ovd_seen = s_q.ovd_seen | s_q.done_latch;
        s_d.wd_cnt = '0;
      end else begin
        s_d.wd_cnt = s_q.wd_cnt + 9'd1;
      end
    end

    // Wishbone slave, one wait state, unmapped reads return zero
    s_d.ack = wb_req;
    if (wb_req) begin
      unique case (wb_adr_i)
        CTRL_OFS: s_d.rdata = ctrl_word;
        TIMING_OFS: s_d.rdata = {8'h00, s_q.timing};
        STATUS_OFS: s_d.rdata = status_word;
        default: s_d.rdata = 32'h0000_0000;
      endcase
      if (wb_we_i && wb_adr_i == CTRL_OFS) begin
        if (wb_sel_i[0]) begin
          s_d.static_mode = wb_dat_i[CTRL_STATIC_BIT];
          if (wb_dat_i[CTRL_CLR_OVD_BIT] && !s_d.overdue) begin
            s_d.ovd_seen = 1'b0;
          end
        end
      end
      if (wb_we_i && wb_adr_i == TIMING_OFS) begin
        s_d.timing = (s_q.timing & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      end
    end
    if (s_q.static_mode) begin
      s_d.ref_req = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.ctl <= '{precharge: 1'b1, default: 1'b0};
      s_q.timing <= TIMING_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign mem_ctl_o = s_q.ctl;
  assign matrix_row_lines_o = s_q.row_lines;
  assign refresh_grant_o = s_q.grant;
  assign refresh_overdue_o = s_q.overdue;
  assign host_done_o = s_q.host_done;

endmodule : refresh_timeout_arbiter
`default_nettype wire

/* File: dv/host_bus_model.sv */
// Host request side model that drives the arbiter host pins
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic stall_i,
  input wire logic wr_i,
  input wire logic [4:0] row_i,
  input wire logic done_i,
  output logic req_o,
  output logic wr_o,
  output logic proceed_o,
  output logic [4:0] row_o
);
  logic wr_q;
  logic [4:0] row_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_o <= 1'b0;
      wr_q <= 1'b0;
      row_q <= 5'h00;
    end else if (go_i) begin
      req_o <= 1'b1;
      wr_q <= wr_i;
      row_q <= row_i;
    end else if (done_i) begin
      req_o <= 1'b0;
    end
    proceed_o <= !stall_i;
  end
  // Released lines show the inverse of the last value
  assign wr_o = req_o ? wr_q : !wr_q;
  assign row_o = req_o ? row_q : ~row_q;
endmodule : host_bus_model
`default_nettype wire

/* File: dv/refresh_timeout_arbiter_properties.sv */
// Concurrent checks on the arbiter ports
`timescale 1ns/1ps
`default_nettype none
module arb_props
  import refresh_timeout_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire mem_ctl_t mem_ctl_o,
  input wire logic refresh_grant_o,
  input wire logic refresh_overdue_o,
  input wire logic host_done_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  ovd_pulse_a: assert property (refresh_overdue_o |=> !refresh_overdue_o)
    else $error("overdue longer than one cycle");
  steal_grant_a: assert property (refresh_overdue_o |-> ##[1:3] refresh_grant_o [*8])
    else $error("no steal after overdue");
  ovd_held_a: assert property (refresh_overdue_o |-> mem_ctl_o.chip_select_strobe)
    else $error("overdue without held access");
  ref_no_wr_a: assert property (refresh_grant_o |-> !mem_ctl_o.write_strobe)
    else $error("write strobe during refresh");
  wr_sync_a: assert property (mem_ctl_o.write_strobe |-> mem_ctl_o.mem_sync)
    else $error("write strobe without sync");
  done_excl_a: assert property (host_done_o |-> !refresh_grant_o ##1 !host_done_o)
    else $error("host done during refresh or held");
endmodule : arb_props
bind refresh_timeout_arbiter arb_props u_arb_props (.core_clk_i, .resetn_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .mem_ctl_o, .refresh_grant_o, .refresh_overdue_o, .host_done_o);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the refresh timeout arbiter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((e) !== (a)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module tb_top
  import refresh_timeout_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, e_v, rnd;
  logic ack, req, hwr, proceed, grant, ovd, done, seen;
  logic go = 1'b0;
  logic stall = 1'b0;
  logic wr = 1'b0;
  logic low = 1'b0;
  logic [4:0] row = 5'h00;
  logic [4:0] hrow, mrow, r0;
  logic [3:0] wcnt = 4'h0;
  mem_ctl_t ctl;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int check_count = 0;
  int cyc_n = 0;
  wire logic [3:0] flags = {ctl.chip_select_strobe, done, ovd, grant};
  refresh_timeout_arbiter u_refresh_timeout_arbiter (.core_clk_i(clk), .resetn_i(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .host_access_request_i(req),
    .host_write_i(hwr), .host_proceed_i(proceed), .host_row_i(hrow),
    .memory_supply_low_i(low), .mem_ctl_o(ctl), .matrix_row_lines_o(mrow),
    .refresh_grant_o(grant), .refresh_overdue_o(ovd), .host_done_o(done));
  host_bus_model u_host_bus_model (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .stall_i(stall),
    .wr_i(wr), .row_i(row), .done_i(done), .req_o(req), .wr_o(hwr), .proceed_o(proceed),
    .row_o(hrow));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    wcnt <= go ? 4'h0 : wcnt + 4'(ctl.write_strobe === 1'b1);
    cyc_n++;
    if (ack === 1'b1 && !we) begin
      e_v = exp_q.pop_front();
      `CHK("read data", e_v, rdat)
    end
    if (cyc_n == 12000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // Flags: 0 grant, 1 overdue, 2 host done, 3 chip select
  task automatic wait_on(input int k, input logic v, input int n);
    repeat (n) begin
      if (flags[k] === v) return;
      @(posedge clk);
    end
    miscompares++;
    $display("mismatch flag %0d expected %b seen %b", k, v, flags[k]);
  endtask : wait_on
  task automatic quiet(input string n);
    seen = 1'b0;
    repeat (800) begin
      @(posedge clk);
      seen |= grant;
    end
    `CHK(n, 1'b0, seen)
  endtask : quiet
  task automatic access(input logic w);
    row <= 5'($urandom());
    wr <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : access
  initial begin
    void'($urandom(47836));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(TIMING_OFS, {8'h00, TIMING_RESET});
    rnd = $urandom();
    wb(1'b1, TIMING_OFS, rnd);
    rd(TIMING_OFS, {8'h00, rnd[23:0]});
    wb(1'b1, TIMING_OFS, {8'h00, TIMING_RESET});
    wb(1'b1, 8'h0c, rnd);
    rd(8'h0c, 32'h0);
    wait_on(0, 1'b1, 900);
    @(posedge clk);
    r0 = mrow;
    wait_on(0, 1'b0, 40);
    wait_on(0, 1'b1, 900);
    @(posedge clk);
    `CHK("row counter", r0 + 5'h01, mrow)
    wait_on(0, 1'b0, 40);
    access(1'b1);
    wait_on(3, 1'b1, 40);
    `CHK("host row", row, mrow)
    `CHK("precharge end", 1'b0, ctl.precharge)
    wait_on(2, 1'b1, 60);
    `CHK("write width", TIMING_RESET[23:20], wcnt)
    stall <= 1'b1;
    access(1'b0);
    wait_on(1, 1'b1, 1300);
    wait_on(0, 1'b1, 4);
    wait_on(0, 1'b0, 20);
    `CHK("select kept", 1'b1, ctl.chip_select_strobe)
    `CHK("held access", 1'b0, done)
    `CHK("sync kept", 1'b1, ctl.mem_sync)
    stall <= 1'b0;
    wait_on(2, 1'b1, 30);
    `CHK("read no write", 4'h0, wcnt)
    wb(1'b1, CTRL_OFS, 32'h1);
    rd(CTRL_OFS, 32'h1);
    quiet("static mode");
    low <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b1, CTRL_OFS, 32'h0);
    quiet("supply low");
    low <= 1'b0;
    wait_on(0, 1'b1, 800);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
